//--- hw/mmrd_decoder.v
// Memory map decoder with remap of the low window, two bus masters.
// Assumes masters hold address and valid while their stall is high.
`timescale 1ns/1ps
`default_nettype none
`include "mmrd_map.vh"

module mmrd_decoder (
    input  wire        mclk_in,
    input  wire        rst_n_in,
    input  wire        remap_wr_in,
    input  wire [1:0]  remap_val_in,
    output wire [1:0]  remap_out,
    input  wire [9:0]  sram_pwr_en_in,
    input  wire        m0_valid_in,
    input  wire [31:0] m0_addr_in,
    output wire        m0_stall_out,
    output wire        m0_valid_out,
    output wire        m0_err_out,
    output wire [2:0]  m0_target_out,
    output wire [26:0] m0_offset_out,
    output wire [3:0]  m0_sram_blk_out,
    output wire [3:0]  m0_slot_out,
    input  wire        m1_valid_in,
    input  wire [31:0] m1_addr_in,
    output wire        m1_stall_out,
    output wire        m1_valid_out,
    output wire        m1_err_out,
    output wire [2:0]  m1_target_out,
    output wire [26:0] m1_offset_out,
    output wire [3:0]  m1_sram_blk_out,
    output wire [3:0]  m1_slot_out
);

    // ****************************************************************
    // Remap field
    // ****************************************************************
    reg [1:0] remap;

    always @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            remap <= `MMRD_REMAP_RESET;
        end else if (remap_wr_in) begin
            remap <= remap_val_in;
        end
    end

    assign remap_out = remap;

    // ****************************************************************
    // Address decode: returns {err, target, offset}
    // ****************************************************************
    function in_rng;
        input [31:0] a;
        input [31:0] lo;
        input [31:0] hi;
        begin
            in_rng = (a >= lo) && (a < hi);
        end
    endfunction

    function [30:0] decode;
        input [31:0] a;
        input [1:0]  rm;
        reg   [2:0]  t;
        reg   [26:0] o;
        begin
            t = `MMRD_TGT_NONE;
            o = 27'h0;
            // Primary and alias regions first; remap never hides them
            if (in_rng(a, `MMRD_ROM_BASE, `MMRD_ROM_END)) begin
                t = `MMRD_TGT_ROM;
                o = {9'h0, a[17:0]};
            end else if (in_rng(a, `MMRD_FLASH_BASE, `MMRD_FLASH_END) ||
                         in_rng(a, `MMRD_FLASH_A1_BASE, `MMRD_FLASH_A1_END) ||
                         in_rng(a, `MMRD_FLASH_A2_BASE, `MMRD_FLASH_A2_END)) begin
                t = `MMRD_TGT_FLASH;
                o = {8'h0, a[18:0]};
            end else if (in_rng(a, `MMRD_SRAM_BASE, `MMRD_SRAM_END) ||
                         in_rng(a, `MMRD_SRAM_A_BASE, `MMRD_SRAM_A_END)) begin
                t = `MMRD_TGT_SRAM;
                o = {10'h0, a[16:0]};
            end else if (in_rng(a, `MMRD_SFW_BASE, `MMRD_SFW_END) ||
                         in_rng(a, `MMRD_SFW_A_BASE, `MMRD_SFW_A_END)) begin
                t = `MMRD_TGT_SFW;
                o = a[26:0];
            end else if (in_rng(a, `MMRD_APB_BASE, `MMRD_APB_END)) begin
                t = `MMRD_TGT_APB;
                o = {11'h0, a[15:0]};
            end else if (in_rng(a, `MMRD_AHB_BASE, `MMRD_AHB_END)) begin
                t = `MMRD_TGT_AHB;
                o = {8'h0, a[18:0]};
            end else if (in_rng(a, `MMRD_PPB_BASE, `MMRD_PPB_END)) begin
                // Marked only so the core keeps it; no memory is selected
                t = `MMRD_TGT_PPB;
                o = {7'h0, a[19:0]};
            end else if (rm == `MMRD_REMAP_ROM &&
                         in_rng(a, `MMRD_LOW_BASE, `MMRD_LOW_ROM_END)) begin
                t = `MMRD_TGT_ROM;
                o = {9'h0, a[17:0]};
            end else if (rm == `MMRD_REMAP_FLASH &&
                         in_rng(a, `MMRD_LOW_BASE, `MMRD_LOW_FLASH_END)) begin
                t = `MMRD_TGT_FLASH;
                o = {8'h0, a[18:0]};
            end else if (rm == `MMRD_REMAP_SRAM &&
                         in_rng(a, `MMRD_LOW_BASE, `MMRD_LOW_SRAM_END)) begin
                t = `MMRD_TGT_SRAM;
                o = {10'h0, a[16:0]};
            end
            // Remap code 3 selects nothing, so the low window errors
            decode = {(t == `MMRD_TGT_NONE), t, o};
        end
    endfunction

    // Block index from SRAM offset: blocks 0..2 are small, 3..9 are 16 kB
    function [3:0] sram_blk;
        input [16:0] o;
        reg   [2:0]  g;
        begin
            g = o[`MMRD_SRAM_GRP_MSB:`MMRD_SRAM_GRP_LSB];
            if (g != 3'h0) begin
                sram_blk = {1'b0, g} + {1'b0, `MMRD_SRAM_BLK_OFS};
            end else if (o[13]) begin
                sram_blk = 4'h2;
            end else if (o[12]) begin
                sram_blk = 4'h1;
            end else begin
                sram_blk = 4'h0;
            end
        end
    endfunction

    // ****************************************************************
    // Per-master decode
    // ****************************************************************
    wire [30:0] dec0 = decode(m0_addr_in, remap);
    wire [30:0] dec1 = decode(m1_addr_in, remap);
    wire [2:0]  tgt0 = dec0[29:27];
    wire [2:0]  tgt1 = dec1[29:27];
    wire [3:0]  blk0 = sram_blk(dec0[16:0]);
    wire [3:0]  blk1 = sram_blk(dec1[16:0]);

    // A powered-down block answers with an error instead of being selected
    wire off0 = (tgt0 == `MMRD_TGT_SRAM) && !sram_pwr_en_in[blk0];
    wire off1 = (tgt1 == `MMRD_TGT_SRAM) && !sram_pwr_en_in[blk1];
    wire err0 = dec0[30] | off0;
    wire err1 = dec1[30] | off1;

    // ****************************************************************
    // Concurrency between the two masters
    // ****************************************************************
    // Master 0 has fixed priority. SRAM blocks are separate paths, so only
    // a same-block hit collides there; other shared targets collide on any
    // hit. Private bus and error accesses never collide.
    wire shared0 = !err0 && (tgt0 != `MMRD_TGT_PPB);
    wire shared1 = !err1 && (tgt1 != `MMRD_TGT_PPB);
    wire same_tgt = (tgt0 == tgt1);
    wire clash = m0_valid_in && m1_valid_in && shared0 && shared1 && same_tgt &&
                 ((tgt0 != `MMRD_TGT_SRAM) || (blk0 == blk1));

    assign m0_stall_out = 1'b0;
    assign m1_stall_out = clash;

    wire load0 = m0_valid_in;
    wire load1 = m1_valid_in && !clash;

    // ****************************************************************
    // Registered outputs
    // ****************************************************************
    mmrd_port_reg u_port0 (
        .mclk_in      (mclk_in),
        .rst_n_in     (rst_n_in),
        .load_in      (load0),
        .err_in       (err0),
        .target_in    (err0 ? `MMRD_TGT_NONE : tgt0),
        .offset_in    (dec0[26:0]),
        .sram_blk_in  (blk0),
        .slot_in      (m0_addr_in[`MMRD_SLOT_MSB:`MMRD_SLOT_LSB]),
        .valid_out    (m0_valid_out),
        .err_out      (m0_err_out),
        .target_out   (m0_target_out),
        .offset_out   (m0_offset_out),
        .sram_blk_out (m0_sram_blk_out),
        .slot_out     (m0_slot_out)
    );

    mmrd_port_reg u_port1 (
        .mclk_in      (mclk_in),
        .rst_n_in     (rst_n_in),
        .load_in      (load1),
        .err_in       (err1),
        .target_in    (err1 ? `MMRD_TGT_NONE : tgt1),
        .offset_in    (dec1[26:0]),
        .sram_blk_in  (blk1),
        .slot_in      (m1_addr_in[`MMRD_SLOT_MSB:`MMRD_SLOT_LSB]),
        .valid_out    (m1_valid_out),
        .err_out      (m1_err_out),
        .target_out   (m1_target_out),
        .offset_out   (m1_offset_out),
        .sram_blk_out (m1_sram_blk_out),
        .slot_out     (m1_slot_out)
    );

endmodule // mmrd_decoder

`default_nettype wire

//--- hw/mmrd_map.vh
// Address map constants for the memory map remap decoder.
// Assumes 32-bit byte addresses from every bus master.
`ifndef MMRD_MAP_VH
`define MMRD_MAP_VH

// ****************************************************************
// Region bounds, base inclusive, end exclusive
// ****************************************************************
`define MMRD_LOW_BASE       32'h0000_0000
`define MMRD_LOW_ROM_END    32'h0004_0000
`define MMRD_LOW_FLASH_END  32'h0008_0000
`define MMRD_LOW_SRAM_END   32'h0002_0000
`define MMRD_ROM_BASE       32'h0300_0000
`define MMRD_ROM_END        32'h0304_0000
`define MMRD_FLASH_BASE     32'h0100_0000
`define MMRD_FLASH_END      32'h0108_0000
`define MMRD_FLASH_A1_BASE  32'h2100_0000
`define MMRD_FLASH_A1_END   32'h2108_0000
`define MMRD_FLASH_A2_BASE  32'h3100_0000
`define MMRD_FLASH_A2_END   32'h3108_0000
`define MMRD_SRAM_BASE      32'h0400_0000
`define MMRD_SRAM_END       32'h0402_0000
`define MMRD_SRAM_A_BASE    32'h2000_0000
`define MMRD_SRAM_A_END     32'h2002_0000
`define MMRD_SFW_BASE       32'h1000_0000
`define MMRD_SFW_END        32'h1800_0000
`define MMRD_SFW_A_BASE     32'h8000_0000
`define MMRD_SFW_A_END      32'h8800_0000
`define MMRD_APB_BASE       32'h4000_0000
`define MMRD_APB_END        32'h4001_0000
`define MMRD_AHB_BASE       32'h4008_0000
`define MMRD_AHB_END        32'h4010_0000
`define MMRD_PPB_BASE       32'hE000_0000
`define MMRD_PPB_END        32'hE010_0000

// ****************************************************************
// Remap codes and reset value
// ****************************************************************
`define MMRD_REMAP_ROM      2'h0
`define MMRD_REMAP_FLASH    2'h1
`define MMRD_REMAP_SRAM     2'h2
`define MMRD_REMAP_RESET    2'h0

// ****************************************************************
// Target codes
// ****************************************************************
`define MMRD_TGT_NONE       3'h0
`define MMRD_TGT_ROM        3'h1
`define MMRD_TGT_FLASH      3'h2
`define MMRD_TGT_SRAM       3'h3
`define MMRD_TGT_SFW        3'h4
`define MMRD_TGT_APB        3'h5
`define MMRD_TGT_AHB        3'h6
`define MMRD_TGT_PPB        3'h7

// ****************************************************************
// Field positions
// ****************************************************************
`define MMRD_SLOT_MSB       15
`define MMRD_SLOT_LSB       12
`define MMRD_SRAM_BLKS      10
`define MMRD_SRAM_GRP_MSB   16
`define MMRD_SRAM_GRP_LSB   14
`define MMRD_SRAM_BLK_OFS   3'h2

`endif

//--- hw/mmrd_port_reg.v
// Output register stage for one bus master's decode result.
// Assumes the decoder supplies a fully resolved result every cycle.
`timescale 1ns/1ps
`default_nettype none

module mmrd_port_reg (
    input  wire        mclk_in,
    input  wire        rst_n_in,
    input  wire        load_in,
    input  wire        err_in,
    input  wire [2:0]  target_in,
    input  wire [26:0] offset_in,
    input  wire [3:0]  sram_blk_in,
    input  wire [3:0]  slot_in,
    output reg         valid_out,
    output reg         err_out,
    output reg  [2:0]  target_out,
    output reg  [26:0] offset_out,
    output reg  [3:0]  sram_blk_out,
    output reg  [3:0]  slot_out
);

    // Target is forced to none when no access is taken, so no memory
    // ever sees a stale select.
    always @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            valid_out    <= 1'b0;
            err_out      <= 1'b0;
            target_out   <= 3'h0;
            offset_out   <= 27'h0;
            sram_blk_out <= 4'h0;
            slot_out     <= 4'h0;
        end else begin
            valid_out    <= load_in;
            err_out      <= load_in & err_in;
            target_out   <= load_in ? target_in : 3'h0;
            offset_out   <= load_in ? offset_in : 27'h0;
            sram_blk_out <= load_in ? sram_blk_in : 4'h0;
            slot_out     <= load_in ? slot_in : 4'h0;
        end
    end

endmodule // mmrd_port_reg

`default_nettype wire

//--- test/mmrd_decoder_asserts.sv
// Concurrent checks on the memory map remap decoder ports.
// Assumes one clock domain and an asynchronous active low reset.
`timescale 1ns/1ps
`default_nettype none

module mmrd_decoder_asserts (
    input wire logic        mclk_in,
    input wire logic        rst_n_in,
    input wire logic        remap_wr_in,
    input wire logic [1:0]  remap_val_in,
    input wire logic [1:0]  remap_out,
    input wire logic        m0_valid_in,
    input wire logic [31:0] m0_addr_in,
    input wire logic        m0_err_out,
    input wire logic [2:0]  m0_target_out,
    input wire logic [26:0] m0_offset_out,
    input wire logic [3:0]  m0_slot_out,
    input wire logic        m1_valid_in,
    input wire logic        m1_stall_out,
    input wire logic        m1_valid_out
);
    default clocking cb @(posedge mclk_in); endclocking
    default disable iff (!rst_n_in);
    // Base inclusive, end exclusive, as the map is written
    function automatic bit rg(input logic [31:0] a, input logic [31:0] lo, input logic [31:0] hi);
        return a >= lo && a < hi;
    endfunction
    wire logic [31:0] a = m0_addr_in;
    property p_rst; $rose(rst_n_in) |-> remap_out == 2'h0; endproperty
    a_rst: assert property (p_rst) else $error("remap not zero after reset");
    property p_remap; remap_wr_in |=> remap_out == $past(remap_val_in); endproperty
    a_remap: assert property (p_remap) else $error("remap write lost");
    property p_rom; m0_valid_in && rg(a, 32'h0300_0000, 32'h0304_0000) |=>
        m0_target_out == 3'h1 && !m0_err_out && m0_offset_out == $past(a[17:0]); endproperty
    a_rom: assert property (p_rom) else $error("rom primary decode");
    // With the SRAM in the low window a powered-off block may answer with an error
    property p_low; m0_valid_in && a < 32'h0002_0000 |=> $past(remap_out) == 2'h3 ? m0_err_out :
        m0_err_out ? $past(remap_out) == 2'h2 : m0_target_out == {1'b0, $past(remap_out)} + 3'h1;
    endproperty
    a_low: assert property (p_low) else $error("low window decode");
    property p_flash; m0_valid_in && (rg(a, 32'h0100_0000, 32'h0108_0000) ||
        rg(a, 32'h2100_0000, 32'h2108_0000) || rg(a, 32'h3100_0000, 32'h3108_0000)) |=>
        m0_target_out == 3'h2 && m0_offset_out == $past(a[18:0]); endproperty
    a_flash: assert property (p_flash) else $error("flash decode");
    property p_sfw; m0_valid_in && (rg(a, 32'h1000_0000, 32'h1800_0000) || rg(a, 32'h8000_0000, 32'h8800_0000))
        |=> m0_target_out == 3'h4 && m0_offset_out == $past(a[26:0]); endproperty
    a_sfw: assert property (p_sfw) else $error("serial flash window decode");
    property p_slot; m0_valid_in && a[31:16] == 16'h4000 |=>
        m0_target_out == 3'h5 && m0_slot_out == $past(a[15:12]); endproperty
    a_slot: assert property (p_slot) else $error("peripheral slot decode");
    property p_err; m0_err_out |-> m0_target_out == 3'h0; endproperty
    a_err: assert property (p_err) else $error("error reached a target");
    property p_m1; m1_valid_in && !m1_stall_out |=> m1_valid_out ##1 !m1_valid_out || $past(m1_valid_in);
    endproperty
    a_m1: assert property (p_m1) else $error("second master not answered");
    property p_stall; m1_stall_out |-> m0_valid_in && m1_valid_in; endproperty
    a_stall: assert property (p_stall) else $error("stall without collision");
endmodule // mmrd_decoder_asserts

bind mmrd_decoder mmrd_decoder_asserts u_mmrd_decoder_asserts (.mclk_in(mclk_in), .rst_n_in(rst_n_in),
    .remap_wr_in(remap_wr_in), .remap_val_in(remap_val_in), .remap_out(remap_out), .m0_valid_in(m0_valid_in),
    .m0_addr_in(m0_addr_in), .m0_err_out(m0_err_out), .m0_target_out(m0_target_out),
    .m0_offset_out(m0_offset_out), .m0_slot_out(m0_slot_out), .m1_valid_in(m1_valid_in),
    .m1_stall_out(m1_stall_out), .m1_valid_out(m1_valid_out));

`default_nettype wire

//--- test/mmrd_master_model.sv
// Second bus master issuing random SRAM accesses.
// Assumes the decoder's stall asks it to hold the request unchanged.
`timescale 1ns/1ps
`default_nettype none

module mmrd_master_model (
    input  wire logic        mclk_in,
    input  wire logic        rst_n_in,
    input  wire logic        stall_in,
    output var  logic        valid_out,
    output var  logic [31:0] addr_out
);
    integer seed = 32'h87C510D0;
    // SRAM only, so that collisions with the first master happen often
    always @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            valid_out <= 1'b0;
            addr_out  <= 32'h0400_0000;
        end else if (!(valid_out && stall_in)) begin
            valid_out <= 1'($random(seed));
            // At least half of the accesses go to block 3, where the first master's run collides with them
            addr_out  <= $random(seed) & 1 ? 32'h0400_4000 | ($random(seed) & 32'h0000_3FFC)
                                           : 32'h0400_0000 | ($random(seed) & 32'h0001_FFFC);
        end
    end
endmodule // mmrd_master_model

`default_nettype wire

//--- test/tb_mmrd_decoder.sv
// Self-checking bench for the memory map remap decoder.
// Assumes one result per taken request, one cycle later.
`timescale 1ns/1ps
`default_nettype none

module tb_mmrd_decoder;
    typedef struct packed {logic [2:0] t; logic e; logic [26:0] o;} mmrd_exp_t;
    logic mclk_in, rst_n_in, remap_wr_in, m0_valid_in, m1_valid_in, m0_stall_out, m1_stall_out;
    logic m0_valid_out, m1_valid_out, m0_err_out, m1_err_out;
    logic [1:0] remap_val_in, remap_out;
    logic [9:0] sram_pwr_en_in;
    logic [31:0] m0_addr_in, m1_addr_in;
    logic [2:0] m0_target_out, m1_target_out;
    logic [26:0] m0_offset_out, m1_offset_out;
    logic [3:0] m0_sram_blk_out, m1_sram_blk_out, m0_slot_out, m1_slot_out;
    mmrd_exp_t q[$];
    mmrd_exp_t x;
    logic [16:0] q1[$];
    logic [16:0] y;
    logic [26:0] ro;
    integer errors = 0, samples_checked = 0, cycles = 0, r;
    integer seed = 32'h87C510D0;

    mmrd_decoder u_mmrd_decoder (.mclk_in(mclk_in), .rst_n_in(rst_n_in), .remap_wr_in(remap_wr_in),
        .remap_val_in(remap_val_in), .remap_out(remap_out), .sram_pwr_en_in(sram_pwr_en_in),
        .m0_valid_in(m0_valid_in), .m0_addr_in(m0_addr_in), .m0_stall_out(m0_stall_out),
        .m0_valid_out(m0_valid_out), .m0_err_out(m0_err_out), .m0_target_out(m0_target_out),
        .m0_offset_out(m0_offset_out), .m0_sram_blk_out(m0_sram_blk_out), .m0_slot_out(m0_slot_out),
        .m1_valid_in(m1_valid_in), .m1_addr_in(m1_addr_in), .m1_stall_out(m1_stall_out),
        .m1_valid_out(m1_valid_out), .m1_err_out(m1_err_out), .m1_target_out(m1_target_out),
        .m1_offset_out(m1_offset_out), .m1_sram_blk_out(m1_sram_blk_out), .m1_slot_out(m1_slot_out));
    mmrd_master_model u_mmrd_master_model (.mclk_in(mclk_in), .rst_n_in(rst_n_in), .stall_in(m1_stall_out),
        .valid_out(m1_valid_in), .addr_out(m1_addr_in));

    initial begin
        mclk_in = 1'b0;
        forever #2.5 mclk_in = ~mclk_in;
    end

    task check(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            errors++;
            $display("Error %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // Block starts 0x0000, 0x1000, 0x2000, then 16 kB blocks from 0x4000
    function automatic logic [3:0] blk(input logic [26:0] o);
        if (o >= 27'h4000) return 4'(o / 27'h4000 + 2);
        return o >= 27'h2000 ? 4'h2 : o >= 27'h1000 ? 4'h1 : 4'h0;
    endfunction

    task summarize;
        $display("checked %0d errors %0d", samples_checked, errors);
        if (errors == 0 && samples_checked > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask

    // Held for one cycle only, so calls chain into back-to-back requests
    task req(input logic [31:0] a, input logic [2:0] t, input logic e, input logic [26:0] o);
        @(posedge mclk_in);
        m0_valid_in <= 1'b1;
        m0_addr_in  <= a;
        q.push_back({t, e, o});
    endtask

    task set_remap(input logic [1:0] v);
        @(posedge mclk_in);
        m0_valid_in  <= 1'b0;
        remap_wr_in  <= 1'b1;
        remap_val_in <= v;
        @(posedge mclk_in);
        remap_wr_in <= 1'b0;
        // The write lands at the edge above, so look one edge later
        @(posedge mclk_in);
        check(remap_out, v);
    endtask

    // ****************************************************************
    // Result monitor
    // ****************************************************************
    always @(posedge mclk_in) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            errors++;
            summarize();
        end
    end

    always @(posedge mclk_in) begin
        if (rst_n_in && m0_valid_out === 1'b1) begin
            x = q.pop_front();
            check(m0_target_out, x.t);
            check(m0_err_out, x.e);
            check(m0_stall_out, 1'b0);
            if (!x.e) check(m0_offset_out, x.o);
            if (x.t == 3'h3) check(m0_sram_blk_out, blk(x.o));
            if (x.t == 3'h5) check(m0_slot_out, x.o[15:12]);
        end
        // Second master: note each taken request, compare its result one cycle later
        if (rst_n_in && m1_valid_in === 1'b1 && m1_stall_out === 1'b0) q1.push_back(m1_addr_in[16:0]);
        if (rst_n_in && m1_valid_out === 1'b1) begin
            y = q1.pop_front();
            check(m1_err_out, !sram_pwr_en_in[blk(y)]);
            check(m1_target_out, sram_pwr_en_in[blk(y)] ? 3'h3 : 3'h0);
            check(m1_offset_out, y);
            check(m1_sram_blk_out, blk(y));
            check(m1_slot_out, y[15:12]);
        end
    end

    initial begin
        rst_n_in = 1'b0;
        {remap_wr_in, m0_valid_in, remap_val_in, m0_addr_in} = '0;
        sram_pwr_en_in = 10'h1FF;
        repeat (10) @(posedge mclk_in);
        rst_n_in <= 1'b1;
        @(posedge mclk_in);
        check(remap_out, 2'h0);
        req(32'h0300_0010, 3'h1, 1'b0, 27'h10);
        req(32'h0304_0000, 3'h0, 1'b1, 27'h0);
        req(32'h0003_FFFC, 3'h1, 1'b0, 27'h3FFFC);
        req(32'h0004_0000, 3'h0, 1'b1, 27'h0);
        req(32'h2107_FFFC, 3'h2, 1'b0, 27'h7FFFC);
        req(32'h3100_0008, 3'h2, 1'b0, 27'h8);
        req(32'h2001_0000, 3'h3, 1'b0, 27'h10000);
        req(32'h0401_C000, 3'h0, 1'b1, 27'h0);
        req(32'h87FF_FFFC, 3'h4, 1'b0, 27'h7FF_FFFC);
        req(32'h1800_0000, 3'h0, 1'b1, 27'h0);
        req(32'h4000_3004, 3'h5, 1'b0, 27'h3004);
        req(32'hE000_0000, 3'h7, 1'b0, 27'h0);
        req(32'h0500_0000, 3'h0, 1'b1, 27'h0);
        for (r = 0; r < 4; r++) begin
            set_remap(r[1:0]);
            req(32'h0000_0100, r == 3 ? 3'h0 : r[2:0] + 3'h1, r == 3, 27'h100);
            req(32'h0000_FFFC | (r[0] ? 32'h0007_0000 : 32'h0), r == 3 ? 3'h0 : r[2:0] + 3'h1,
                r == 3, r[0] ? 27'h7FFFC : 27'hFFFC);
            req(32'h0400_2000, 3'h3, 1'b0, 27'h2000);
            req(32'h1000_0000, 3'h4, 1'b0, 27'h0);
        end
        set_remap(2'h2);
        req(32'h0002_0000, 3'h0, 1'b1, 27'h0);
        req(32'h0001_0004, 3'h3, 1'b0, 27'h10004);
        repeat (20) begin
            ro = 27'($random(seed)) & 27'h3FFFC;
            req(32'h0300_0000 | ro, 3'h1, 1'b0, ro);
        end
        // Run on block 3 so the second master is stalled and then released
        repeat (20) begin
            ro = 27'h4000 | (27'($random(seed)) & 27'h3FFC);
            req(32'h0400_0000 | ro, 3'h3, 1'b0, ro);
        end
        @(posedge mclk_in);
        m0_valid_in <= 1'b0;
        repeat (4) @(posedge mclk_in);
        check(q.size(), 0);
        check(q1.size() < 2, 1'b1);
        summarize();
    end
endmodule // tb_mmrd_decoder

`default_nettype wire
